// >>> core/gfs_pin_mux.sv
// top of the pin function multiplexer
`timescale 1ns/1ps
// Contract
// - each pin's code selects the status signal driven onto it
// - differential enable codes OR the pin into that output's enable bit
// - single-ended enable codes OR the pin into that output's enable bit
// - stop-clock bit1 and bit0 inputs exist for dividers C and D of four synthesizers
// - each stop input ORs into its stop-clock register bit, first code 0x44
// - code 0x80 drives the pin with the device interrupt
// - code 0x88 drives reference 0 precise monitor failure
// - code 0x89 drives reference 0 single-cycle monitor failure
// - code 0x8A drives reference 0 coarse monitor failure
// - code 0x8B drives reference 0 guard soak timer indicator
// - code 0x8C drives reference 0 masked failure summary
// - references 1 to 7 repeat the five functions up to 0xAF
// - code 0xC0 drives high while loop 0 is in normal state
// - code 0xC1 drives high while loop 0 is in holdover
// - code 0x00 leaves the pin an input with no function
module gfs_pin_mux (
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // pins
   input wire logic [gfs_pkg::NUM_PINS-1:0] pin_in_i,
   output logic [gfs_pkg::NUM_PINS-1:0] pin_out_o,
   output logic [gfs_pkg::NUM_PINS-1:0] pin_oe_o,
   // configuration
   input wire gfs_pkg::gfs_code_arr_t func_sel_i,
   input wire logic [gfs_pkg::NUM_OUTS-1:0] diff_output_enable_reg_i,
   input wire logic [gfs_pkg::NUM_OUTS-1:0] single_ended_enable_reg_i,
   input wire logic [gfs_pkg::NUM_STOP-1:0] synth_stop_clock_reg_i,
   input wire logic [gfs_pkg::NUM_REFS-1:0] mask_los_i,
   input wire logic [gfs_pkg::NUM_REFS-1:0] mask_scm_i,
   input wire logic [gfs_pkg::NUM_REFS-1:0] mask_cfm_i,
   input wire logic [gfs_pkg::NUM_REFS-1:0] mask_gst_i,
   // internal status sources
   input wire logic irq_i,
   input wire logic [gfs_pkg::NUM_REFS-1:0] pfm_fail_i,
   input wire logic [gfs_pkg::NUM_REFS-1:0] scm_fail_i,
   input wire logic [gfs_pkg::NUM_REFS-1:0] cfm_fail_i,
   input wire logic [gfs_pkg::NUM_REFS-1:0] gst_i,
   input wire logic [gfs_pkg::NUM_LOOPS-1:0] loop_normal_i,
   input wire logic [gfs_pkg::NUM_LOOPS-1:0] loop_holdover_i,
   // merged controls
   output logic [gfs_pkg::NUM_OUTS-1:0] diff_output_enable_o,
   output logic [gfs_pkg::NUM_OUTS-1:0] single_ended_enable_o,
   output logic [gfs_pkg::NUM_STOP-1:0] synth_stop_clock_o,
   output logic [gfs_pkg::NUM_REFS-1:0] loss_of_signal_o,
   output logic [gfs_pkg::NUM_REFS-1:0] ref_fail_o
);
   import gfs_pkg::*;

   logic [NUM_PINS-1:0] pin_sync;
   logic [NUM_PINS-1:0] pin_out_next;
   logic [NUM_PINS-1:0] pin_oe_next;
   logic [NUM_PINS-1:0] pin_out_reg;
   logic [NUM_PINS-1:0] pin_oe_reg;
   logic [NUM_OUTS-1:0] diff_en_reg;
   logic [NUM_OUTS-1:0] se_en_reg;
   logic [NUM_STOP-1:0] stop_reg;
   logic [NUM_REFS-1:0] los_reg;
   logic [NUM_REFS-1:0] fail_reg;
   wire [NUM_REFS-1:0] ref_fail;
   wire [NUM_OUTS-1:0] diff_en_next;
   wire [NUM_OUTS-1:0] se_en_next;
   wire [NUM_STOP-1:0] stop_next;

   gfs_ctl_if ctl ();

   gfs_sync2 u_sync (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .async_i(pin_in_i),
      .sync_o(pin_sync)
   );

   gfs_pin_decode u_decode (
      .code_i(func_sel_i),
      .level_i(pin_sync),
      .ctl(ctl.src)
   );

   // failure summary uses the synced loss-of-signal pins
   assign ref_fail = (los_reg & mask_los_i) | (scm_fail_i & mask_scm_i)
                   | (cfm_fail_i & mask_cfm_i) | (gst_i & mask_gst_i);
   assign diff_en_next = diff_output_enable_reg_i | ctl.diff_en;
   assign se_en_next = single_ended_enable_reg_i | ctl.se_en;
   assign stop_next = synth_stop_clock_reg_i | ctl.stop;

   // returns {drive, level} for one status code; undefined codes return 0
   function automatic logic [1:0] status_drive(
      input gfs_code_t c,
      input logic irq,
      input logic [NUM_REFS-1:0] pfm,
      input logic [NUM_REFS-1:0] scm,
      input logic [NUM_REFS-1:0] cfm,
      input logic [NUM_REFS-1:0] guard_soak_timer,
      input logic [NUM_REFS-1:0] fail,
      input logic [NUM_LOOPS-1:0] nrm,
      input logic [NUM_LOOPS-1:0] hold
   );
      logic [1:0] r;
      gfs_code_t base;
      r = 2'h0;
      base = FN_NONE;
      if (c == FN_IRQ) begin
         r = {1'b1, irq};
      end
      for (int i = 0; i < NUM_REFS; i++) begin
         base = FN_REF_FIRST + gfs_code_t'(i * REF_FUNCS);
         if (c == base + gfs_code_t'(REF_PFM)) begin
            r = {1'b1, pfm[i]};
         end
         if (c == base + gfs_code_t'(REF_SCM)) begin
            r = {1'b1, scm[i]};
         end
         if (c == base + gfs_code_t'(REF_CFM)) begin
            r = {1'b1, cfm[i]};
         end
         if (c == base + gfs_code_t'(REF_GST)) begin
            r = {1'b1, guard_soak_timer[i]};
         end
         if (c == base + gfs_code_t'(REF_FAIL)) begin
            r = {1'b1, fail[i]};
         end
      end
      for (int l = 0; l < NUM_LOOPS; l++) begin
         base = FN_LOOP_FIRST + gfs_code_t'(l) * FN_LOOP_STRIDE;
         if (c == base + LOOP_NORMAL) begin
            r = {1'b1, nrm[l]};
         end
         if (c == base + LOOP_HOLD) begin
            r = {1'b1, hold[l]};
         end
      end
      return r;
   endfunction : status_drive

   generate
      for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
         wire [1:0] drv;
         assign drv = status_drive(func_sel_i[p], irq_i, pfm_fail_i, scm_fail_i,
                                   cfm_fail_i, gst_i, ref_fail, loop_normal_i,
                                   loop_holdover_i);
         assign pin_oe_next[p] = drv[1];
         assign pin_out_next[p] = drv[1] & drv[0];
      end
   endgenerate

   // registering every output costs one cycle of latency but keeps pins glitch free
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pin_out_reg <= PIN_RST;
         pin_oe_reg <= PIN_RST;
         diff_en_reg <= EN_RST;
         se_en_reg <= EN_RST;
         stop_reg <= STOP_RST;
         los_reg <= '0;
         fail_reg <= '0;
      end else begin
         pin_out_reg <= pin_out_next;
         pin_oe_reg <= pin_oe_next;
         diff_en_reg <= diff_en_next;
         se_en_reg <= se_en_next;
         stop_reg <= stop_next;
         los_reg <= ctl.loss_of_signal;
         fail_reg <= ref_fail;
      end
   end

   assign pin_out_o = pin_out_reg;
   assign pin_oe_o = pin_oe_reg;
   assign diff_output_enable_o = diff_en_reg;
   assign single_ended_enable_o = se_en_reg;
   assign synth_stop_clock_o = stop_reg;
   assign loss_of_signal_o = los_reg;
   assign ref_fail_o = fail_reg;
endmodule : gfs_pin_mux

// >>> core/gfs_pkg.sv
// constants and types for the pin function multiplexer
package gfs_pkg;
   localparam int NUM_PINS = 7;
   localparam int NUM_REFS = 8;
   localparam int NUM_OUTS = 8;
   localparam int NUM_LOOPS = 4;
   localparam int NUM_STOP = 16;
   localparam int REF_FUNCS = 5;
   typedef logic [7:0] gfs_code_t;
   typedef gfs_code_t [NUM_PINS-1:0] gfs_code_arr_t;
   // function codes
   localparam gfs_code_t FN_NONE = 8'h00;
   localparam gfs_code_t FN_LOS_FIRST = 8'h10;
   localparam gfs_code_t FN_LOS_LAST = 8'h17;
   localparam gfs_code_t FN_STOP_FIRST = 8'h44;
   localparam gfs_code_t FN_STOP_LAST = 8'h53;
   localparam gfs_code_t FN_DIFF_FIRST = 8'h60;
   localparam gfs_code_t FN_DIFF_LAST = 8'h6E;
   localparam gfs_code_t FN_SE_FIRST = 8'h70;
   localparam gfs_code_t FN_SE_LAST = 8'h7E;
   localparam gfs_code_t FN_IRQ = 8'h80;
   localparam gfs_code_t FN_REF_FIRST = 8'h88;
   localparam gfs_code_t FN_REF_LAST = 8'hAF;
   localparam gfs_code_t FN_LOOP_FIRST = 8'hC0;
   localparam gfs_code_t FN_LOOP_STRIDE = 8'h10;
   // offsets inside a reference group and a loop group
   localparam int REF_PFM = 0;
   localparam int REF_SCM = 1;
   localparam int REF_CFM = 2;
   localparam int REF_GST = 3;
   localparam int REF_FAIL = 4;
   localparam gfs_code_t LOOP_NORMAL = 8'h00;
   localparam gfs_code_t LOOP_HOLD = 8'h01;
   // reset values
   localparam logic [NUM_PINS-1:0] PIN_RST = 7'h00;
   localparam logic [NUM_OUTS-1:0] EN_RST = 8'h00;
   localparam logic [NUM_STOP-1:0] STOP_RST = 16'h0000;
endpackage : gfs_pkg

// >>> core/gfs_ctl_if.sv
// control-input requests from the pin decoder to the merge logic
`timescale 1ns/1ps
interface gfs_ctl_if;
   logic [gfs_pkg::NUM_REFS-1:0] loss_of_signal;
   logic [gfs_pkg::NUM_OUTS-1:0] diff_en;
   logic [gfs_pkg::NUM_OUTS-1:0] se_en;
   logic [gfs_pkg::NUM_STOP-1:0] stop;
   modport src (output loss_of_signal, output diff_en, output se_en, output stop);
   modport dst (input loss_of_signal, input diff_en, input se_en, input stop);
endinterface : gfs_ctl_if

// >>> core/gfs_sync2.sv
// two-flop synchroniser for the pin inputs
`timescale 1ns/1ps
module gfs_sync2 (
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // async levels in, synced levels out
   input wire logic [gfs_pkg::NUM_PINS-1:0] async_i,
   output logic [gfs_pkg::NUM_PINS-1:0] sync_o
);
   import gfs_pkg::*;
   logic [NUM_PINS-1:0] meta_reg;
   logic [NUM_PINS-1:0] sync_reg;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         meta_reg <= PIN_RST;
         sync_reg <= PIN_RST;
      end else begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
      end
   end
   assign sync_o = sync_reg;
endmodule : gfs_sync2

// >>> core/gfs_pin_decode.sv
// decodes control-input codes of all pins into request vectors
`timescale 1ns/1ps
module gfs_pin_decode (
   // per-pin codes and synced levels
   input wire gfs_pkg::gfs_code_arr_t code_i,
   input wire logic [gfs_pkg::NUM_PINS-1:0] level_i,
   // merged requests
   gfs_ctl_if.src ctl
);
   import gfs_pkg::*;
   function automatic logic in_range(gfs_code_t c, gfs_code_t lo, gfs_code_t hi);
      return (c >= lo) && (c <= hi);
   endfunction : in_range
   always_comb begin
      gfs_code_t c;
      gfs_code_t k;
      c = FN_NONE;
      k = FN_NONE;
      ctl.loss_of_signal = '0;
      ctl.diff_en = EN_RST;
      ctl.se_en = EN_RST;
      ctl.stop = STOP_RST;
      // several pins may target the same bit; their levels simply OR
      for (int p = 0; p < NUM_PINS; p++) begin
         c = code_i[p];
         if (in_range(c, FN_LOS_FIRST, FN_LOS_LAST)) begin
            k = c - FN_LOS_FIRST;
            ctl.loss_of_signal[k[2:0]] = ctl.loss_of_signal[k[2:0]] | level_i[p];
         end
         if (in_range(c, FN_STOP_FIRST, FN_STOP_LAST)) begin
            // even code is bit1, odd code is bit0 of the two-bit field
            k = c - FN_STOP_FIRST;
            ctl.stop[{k[3:1], ~k[0]}] = ctl.stop[{k[3:1], ~k[0]}] | level_i[p];
         end
         if (in_range(c, FN_DIFF_FIRST, FN_DIFF_LAST) && !c[0]) begin
            k = c - FN_DIFF_FIRST;
            ctl.diff_en[k[3:1]] = ctl.diff_en[k[3:1]] | level_i[p];
         end
         if (in_range(c, FN_SE_FIRST, FN_SE_LAST) && !c[0]) begin
            k = c - FN_SE_FIRST;
            ctl.se_en[k[3:1]] = ctl.se_en[k[3:1]] | level_i[p];
         end
      end
   end
endmodule : gfs_pin_decode

// >>> bench/gfs_pin_mux_asserts.sv
// concurrent checks on the pin function multiplexer ports
`timescale 1ns/1ps
module gfs_pin_mux_asserts (
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // pins and configuration
   input wire logic [6:0] pin_in_i,
   input wire logic [6:0] pin_out_o,
   input wire logic [6:0] pin_oe_o,
   input wire gfs_pkg::gfs_code_arr_t func_sel_i,
   input wire logic [7:0] diff_output_enable_reg_i,
   // status sources
   input wire logic irq_i,
   input wire logic [7:0] pfm_fail_i,
   input wire logic [7:0] scm_fail_i,
   input wire logic [7:0] cfm_fail_i,
   input wire logic [7:0] gst_i,
   input wire logic [3:0] loop_normal_i,
   input wire logic [3:0] loop_holdover_i,
   // merged controls
   input wire logic [7:0] diff_output_enable_o,
   input wire logic [15:0] synth_stop_clock_o
);
   import gfs_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // $past would see reset-time values on the first edge after release
   logic up;
   always_ff @(posedge clk_i) up <= !sys_rst_i;
   property p_drv(gfs_code_t c, logic src);
      up && $past(func_sel_i[0]) == c |-> pin_oe_o[0] && pin_out_o[0] == $past(src);
   endproperty
   sequence s_stop_req;
      (pin_in_i[1] && func_sel_i[1] == 8'h44) [*3];
   endsequence
   a_irq_pin: assert property (p_drv(8'h80, irq_i)) else $error("irq pin mismatch");
   a_pfm_ref0: assert property (p_drv(8'h88, pfm_fail_i[0])) else $error("pfm pin");
   a_scm_ref0: assert property (p_drv(8'h89, scm_fail_i[0])) else $error("scm pin");
   a_cfm_ref0: assert property (p_drv(8'h8A, cfm_fail_i[0])) else $error("cfm pin");
   a_gst_ref0: assert property (p_drv(8'h8B, gst_i[0])) else $error("gst pin");
   a_gst_ref7: assert property (p_drv(8'hAE, gst_i[7])) else $error("ref7 gst pin");
   a_loop_normal: assert property (p_drv(8'hC0, loop_normal_i[0])) else $error("normal");
   a_loop_hold: assert property (p_drv(8'hC1, loop_holdover_i[0])) else $error("hold");
   a_idle_pin: assert property (up && $past(func_sel_i[0]) inside {8'h00, 8'h81} |->
      !pin_oe_o[0] && !pin_out_o[0]) else $error("idle pin driven");
   a_diff_reg_or: assert property (up && $past(diff_output_enable_reg_i[0]) |->
      diff_output_enable_o[0]) else $error("diff enable lost");
   a_stop_sync: assert property (s_stop_req |=> synth_stop_clock_o[1])
      else $error("stop bit late");
endmodule : gfs_pin_mux_asserts
bind gfs_pin_mux gfs_pin_mux_asserts u_gfs_pin_mux_asserts (.clk_i, .sys_rst_i, .pin_in_i,
   .pin_out_o, .pin_oe_o, .func_sel_i, .diff_output_enable_reg_i, .irq_i, .pfm_fail_i,
   .scm_fail_i, .cfm_fail_i, .gst_i, .loop_normal_i, .loop_holdover_i,
   .diff_output_enable_o, .synth_stop_clock_o);

// >>> bench/gfs_board_model.sv
// board logic at the pins: drives or releases each pad
`timescale 1ns/1ps
module gfs_board_model (
   // board requests
   input wire logic [6:0] drive_i,
   input wire logic [6:0] level_i,
   // device pad drive
   input wire logic [6:0] pin_out_i,
   input wire logic [6:0] pin_oe_i,
   // resolved pad level
   output logic [6:0] pad_o
);
   // pads carry pull-downs, so a released pad reads low
   always_comb begin
      for (int p = 0; p < 7; p++) begin
         pad_o[p] = pin_oe_i[p] ? pin_out_i[p] : (drive_i[p] & level_i[p]);
      end
   end
endmodule : gfs_board_model

// >>> bench/tb_gfs_pin_mux.sv
// self-checking bench for the pin function multiplexer
`timescale 1ns/1ps
module tb_gfs_pin_mux;
   import gfs_pkg::*;
   logic clk_i = 0;
   logic sys_rst_i = 1;
   gfs_code_arr_t func_sel_i = '0;
   logic [7:0] den = '0, sen = '0, pfm = '0, scm = '0, cfm = '0, guard_soak_timer = '0, deo, seo, loss_of_signal, rfl;
   logic [7:0] mlos = '0, mscm = '0, mcfm = '0, mgst = '0;
   logic [15:0] stp = '0, sto;
   logic [3:0] nrm = '0, hld = '0;
   logic irq = 0;
   logic [6:0] drv = '0, lvl = '0, pin_in, pout, poe;
   int failures = 0, comparisons = 0;
   always #5 clk_i = ~clk_i;
   gfs_pin_mux u_gfs_pin_mux (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .pin_in_i(pin_in),
      .pin_out_o(pout), .pin_oe_o(poe), .func_sel_i(func_sel_i), .diff_output_enable_reg_i(den),
      .single_ended_enable_reg_i(sen), .synth_stop_clock_reg_i(stp), .mask_los_i(mlos),
      .mask_scm_i(mscm), .mask_cfm_i(mcfm), .mask_gst_i(mgst), .irq_i(irq), .pfm_fail_i(pfm),
      .scm_fail_i(scm), .cfm_fail_i(cfm), .gst_i(guard_soak_timer), .loop_normal_i(nrm),
      .loop_holdover_i(hld), .diff_output_enable_o(deo), .single_ended_enable_o(seo),
      .synth_stop_clock_o(sto), .loss_of_signal_o(loss_of_signal), .ref_fail_o(rfl));
   gfs_board_model u_gfs_board_model (.drive_i(drv), .level_i(lvl), .pin_out_i(pout),
      .pin_oe_i(poe), .pad_o(pin_in));
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask : cyc
   task automatic stop_test();
      if (failures == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : stop_test
   task automatic t_status();
      gfs_code_t cs[13] = '{8'h80, 8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'hC0, 8'hC1,
         8'hAB, 8'hAC, 8'hAD, 8'hAE, 8'hAF};
      // one source per code, so a code wired to the wrong source reads low
      logic [40:0] sm[13] = '{41'h100_0000_0000, 41'h1_0000_0000, 41'h1_00_0000, 41'h1_0000,
         41'h100, 41'h1_00_0000, 41'h10, 41'h1, 41'h80_0000_0000, 41'h8000_0000,
         41'h80_0000, 41'h8000, 41'h8000_0000};
      gfs_code_t nul[3] = '{8'h00, 8'h81, 8'h40};
      mscm = 8'hFF;
      foreach (cs[i]) begin
         for (int v = 0; v < 2; v++) begin
            func_sel_i[0] = cs[i];
            {irq, pfm, scm, cfm, guard_soak_timer, nrm, hld} = v[0] ? sm[i] : 41'h0;
            cyc(1);
            chk({poe[0], pout[0]}, {1'b1, v[0]});
         end
      end
      drv[0] = 1;
      lvl[0] = 1;
      foreach (nul[i]) begin
         func_sel_i[0] = nul[i];
         cyc(4);
         chk({poe[0], pout[0], deo, seo, sto}, '0);
      end
      drv[0] = 0;
   endtask : t_status
   task automatic t_ctrl(input gfs_code_t code, input int idx);
      func_sel_i[1] = code;
      cyc(4);
      drv[1] = 1;
      lvl[1] = 1;
      cyc(2);
      chk({sto, seo, deo}, '0);
      cyc(1);
      chk({sto, seo, deo}, 40'h1 << idx);
      drv[1] = 0;
      cyc(4);
   endtask : t_ctrl
   task automatic t_regs();
      den = 8'hA5;
      sen = 8'h3C;
      stp = 16'h8001;
      func_sel_i[1] = 8'h62;
      drv[1] = 1;
      cyc(4);
      chk({sto, seo, deo}, {16'h8001, 8'h3C, 8'hA7});
      drv[1] = 0;
      {den, sen, stp} = '0;
   endtask : t_regs
   task automatic t_los();
      func_sel_i[0] = 8'hAF;
      func_sel_i[1] = 8'h17;
      {irq, pfm, scm, cfm, guard_soak_timer, nrm, hld} = '0;
      drv[1] = 1;
      cyc(5);
      chk({loss_of_signal, rfl, poe[0], pout[0]}, {8'h80, 8'h00, 2'b10});
      mlos = 8'h80;
      cyc(2);
      chk({loss_of_signal, rfl, poe[0], pout[0]}, {8'h80, 8'h80, 2'b11});
   endtask : t_los
   initial begin
      #20000;
      failures++;
      stop_test();
   end
   initial begin
      cyc(12);
      sys_rst_i = 0;
      t_status();
      for (int i = 0; i < 8; i++) begin
         t_ctrl(gfs_code_t'(8'h60 + 2 * i), i);
         t_ctrl(gfs_code_t'(8'h70 + 2 * i), 8 + i);
      end
      for (int s = 0; s < 16; s++) begin
         t_ctrl(gfs_code_t'(8'h44 + s), 16 + (s ^ 1));
      end
      t_regs();
      t_los();
      stop_test();
   end
endmodule : tb_gfs_pin_mux
